// ### hdl/precomp_pkg.sv
// Constants and lookups for the write precompensation and PLL control block
package precomp_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned NS_PER_US = 1000;

  // Data rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_RESET = RATE_250K;
  localparam int unsigned BPS_250K = 250_000;
  localparam int unsigned BPS_300K = 300_000;
  localparam int unsigned BPS_500K = 500_000;
  localparam int unsigned BPS_1M = 1_000_000;

  // Precompensation shifts in ns, and in cycles rounded up
  localparam int unsigned SHIFT_250_NS = 250;
  localparam int unsigned SHIFT_208_NS = 208;
  localparam int unsigned SHIFT_125_NS = 125;
  localparam int unsigned SHIFT_83_NS = 83;
  localparam logic [4:0] STEP_250 = 5'((SHIFT_250_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [4:0] STEP_208 = 5'((SHIFT_208_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [4:0] STEP_125 = 5'((SHIFT_125_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [4:0] STEP_83 = 5'((SHIFT_83_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);

  // Encoded cell is half a data bit; longest time, rounded down
  localparam logic [7:0] CELL_250K = 8'(CLK_HZ / (2 * BPS_250K));
  localparam logic [7:0] CELL_300K = 8'(CLK_HZ / (2 * BPS_300K));
  localparam logic [7:0] CELL_500K = 8'(CLK_HZ / (2 * BPS_500K));
  localparam logic [7:0] CELL_1M = 8'(CLK_HZ / (2 * BPS_1M));

  // Loop oscillator cycles between phase comparisons
  localparam logic [4:0] DIV_1M = 5'h04;
  localparam logic [4:0] DIV_500K = 5'h08;
  localparam logic [4:0] DIV_LOW = 5'h10;

  // Register map (byte addresses) and fields
  localparam logic [11:0] REG_CONTROL = 12'h000;
  localparam logic [11:0] REG_MODE = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam int unsigned MODE_PUMP_BIT = 0;
  localparam int unsigned MODE_GATE_BIT = 1;
  localparam int unsigned ST_STRAP_BIT = 2;
  localparam int unsigned ST_UNDERRUN_BIT = 3;
  localparam int unsigned ST_WRITING_BIT = 4;
  localparam int unsigned ST_DIV_LSB = 5;
  localparam int unsigned ST_VCO_BIT = 10;
  localparam int unsigned ST_STEP_LSB = 11;

  typedef enum logic [1:0] {
    TAP_EARLY = 2'b00,
    TAP_NOMINAL = 2'b01,
    TAP_LATE = 2'b10
  } precomp_tap_t;

  function automatic logic [4:0] step_cycles(input logic [1:0] rate, input logic scaled);
    logic [4:0] s;
    s = STEP_125;
    unique case (rate)
      RATE_1M: s = STEP_83;
      RATE_500K: s = STEP_125;
      RATE_300K: s = scaled ? STEP_208 : STEP_125;
      RATE_250K: s = scaled ? STEP_250 : STEP_125;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] cell_cycles(input logic [1:0] rate);
    logic [7:0] c;
    c = CELL_250K;
    unique case (rate)
      RATE_1M: c = CELL_1M;
      RATE_500K: c = CELL_500K;
      RATE_300K: c = CELL_300K;
      RATE_250K: c = CELL_250K;
    endcase
    return c;
  endfunction
endpackage

// ### hdl/write_precomp_pll_control.sv
// Write precompensation, PLL divider, filter switching and PLL diagnostics
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps

// Functional notes
// [R1] Precompensation uses one three-stage shift register whose taps feed write data.
// [R2] Tap chosen per pulse: early, nominal or late from neighbouring cells.
// [R3] Strap low: 125 ns shift, except 83 ns at 1 Mb/s.
// [R4] Strap high: 250/208/125/83 ns at 250k/300k/500k/1M.
// [R5] Diagnostic mode one drives pump activity onto the shared strap pin.
// [R6] Pump monitor is high while the charge pump corrects phase.
// [R7] Diagnostic mode two lets an external gate force track or reference.
// [R8] Software enables diagnostic modes by mode bits; both off otherwise.
// [R9] Feedback divider 4 at 1M, 8 at 500k, 16 at 300k and 250k.
// [R10] Oscillator centre 4 MHz except 4.8 MHz at 300 kb/s.
// [R11] Mid switch only at 500k, low switch at 250k/300k, none at 1M.
// [R12] After reset the data rate is 250 kb/s.
// [R13] Strap sampled only while not writing, frozen during a write.
module write_precomp_pll_control #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_enable,
  input wire logic cell_word_valid,
  input wire logic [WIDTH-1:0] cell_word,
  output logic cell_word_ready,
  output logic write_data,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic pump_monitor_precomp_select_pin_in,
  output logic pump_monitor_precomp_select_pin_out,
  output logic pump_monitor_precomp_select_pin_oe_n,
  input wire logic core_read_gate,
  input wire logic ext_read_gate,
  output logic track_data,
  output logic [4:0] pll_divider,
  output logic vco_center_high,
  output logic filter_switch_low_rate,
  output logic filter_switch_mid_rate
);
  if (WIDTH < 1 || WIDTH > 32 || DEPTH != 2) begin : bad_params
    $error("write_precomp_pll_control: WIDTH 1..32 and DEPTH 2 only");
  end

  localparam int unsigned CW = $clog2(WIDTH + 1);
  localparam logic [CW-1:0] WORD_LAST = CW'(WIDTH - 1);

  logic [1:0] rate_q;
  logic pump_mon_en_q, ext_gate_en_q, underrun_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic access, setup_phase;

  // APB: one wait state, answer registered
  assign setup_phase = psel && penable && !pready_q;
  assign access = psel && penable && pready_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase && !(paddr == precomp_pkg::REG_CONTROL ||
                   paddr == precomp_pkg::REG_MODE || paddr == precomp_pkg::REG_STATUS);
      if (setup_phase && !pwrite) begin
        prdata_q <= read_word(paddr);
      end else if (access) begin
        prdata_q <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rate_q <= precomp_pkg::RATE_RESET; // see [R12]
      pump_mon_en_q <= 1'b0; // see [R8]
      ext_gate_en_q <= 1'b0;
    end else if (access && pwrite) begin
      if (paddr == precomp_pkg::REG_CONTROL) begin
        rate_q <= pwdata[1:0];
      end
      if (paddr == precomp_pkg::REG_MODE) begin
        pump_mon_en_q <= pwdata[precomp_pkg::MODE_PUMP_BIT];
        ext_gate_en_q <= pwdata[precomp_pkg::MODE_GATE_BIT];
      end
    end
  end

  // Synchronisers: three stages, change taken once stages two and three agree
  logic [2:0] strap_s, pump_s, gate_s;
  logic strap_f, pump_f, gate_f, strap_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_s <= 3'h0;
      pump_s <= 3'h0;
      gate_s <= 3'h0;
      strap_f <= 1'b0;
      pump_f <= 1'b0;
      gate_f <= 1'b0;
    end else begin
      strap_s <= {strap_s[1:0], pump_monitor_precomp_select_pin_in};
      pump_s <= {pump_s[1:0], pump_up || pump_down}; // see [R6]
      gate_s <= {gate_s[1:0], ext_read_gate};
      if (strap_s[1] == strap_s[2]) begin
        strap_f <= strap_s[2];
      end
      if (pump_s[1] == pump_s[2]) begin
        pump_f <= pump_s[2];
      end
      if (gate_s[1] == gate_s[2]) begin
        gate_f <= gate_s[2];
      end
    end
  end

  // Strap held through a write and while the pin is driven
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_q <= 1'b0;
    end else if (!write_enable && !pump_mon_en_q && pump_monitor_precomp_select_pin_oe_n) begin
      strap_q <= strap_f; // see [R13]
    end
  end

  // Diagnostic pin and read gate outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pump_monitor_precomp_select_pin_out <= 1'b0;
      pump_monitor_precomp_select_pin_oe_n <= 1'b1;
      track_data <= 1'b0;
    end else begin
      pump_monitor_precomp_select_pin_out <= pump_mon_en_q && pump_f; // see [R5] see [R6]
      pump_monitor_precomp_select_pin_oe_n <= !pump_mon_en_q; // see [R5]
      track_data <= ext_gate_en_q ? gate_f : core_read_gate; // see [R7]
    end
  end

  // PLL divider, oscillator centre and filter switches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pll_divider <= precomp_pkg::DIV_LOW;
      vco_center_high <= 1'b0;
      filter_switch_low_rate <= 1'b1;
      filter_switch_mid_rate <= 1'b0;
    end else begin
      pll_divider <= (rate_q == precomp_pkg::RATE_1M) ? precomp_pkg::DIV_1M :
                     (rate_q == precomp_pkg::RATE_500K) ? precomp_pkg::DIV_500K :
                     precomp_pkg::DIV_LOW; // see [R9]
      vco_center_high <= rate_q == precomp_pkg::RATE_300K; // see [R10]
      filter_switch_mid_rate <= rate_q == precomp_pkg::RATE_500K; // see [R11]
      filter_switch_low_rate <= rate_q == precomp_pkg::RATE_250K ||
                                rate_q == precomp_pkg::RATE_300K; // see [R11]
    end
  end

  // Two-entry word buffer
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] count_q, count_d;
  logic push, pop, drain_ready;

  assign push = cell_word_valid && cell_word_ready;
  assign pop = drain_ready && count_q != 2'h0;
  assign count_d = 2'(count_q + {1'b0, push} - {1'b0, pop});

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      cell_word_ready <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_d;
      cell_word_ready <= count_d != 2'(DEPTH);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= cell_word;
    end
  end

  // Cell timing and serialiser
  logic [7:0] cell_cnt_q;
  logic [WIDTH-1:0] word_q;
  logic [CW-1:0] left_q;
  logic cell_tick, next_cell;
  logic [4:0] win_q, win_d;
  precomp_pkg::precomp_tap_t tap_d, tap_q;

  assign cell_tick = write_enable && cell_cnt_q == 8'h0;
  assign drain_ready = cell_tick && left_q == '0;
  assign next_cell = (left_q != '0) ? word_q[0] : (pop ? mem[rd_ptr_q][0] : 1'b0);
  assign win_d = {win_q[3:0], next_cell};

  // Pulse moves toward its nearer neighbour to offset peak shift
  always_comb begin
    tap_d = precomp_pkg::TAP_NOMINAL;
    if (win_d[3] && !win_d[1]) begin
      tap_d = precomp_pkg::TAP_EARLY; // see [R2]
    end else if (win_d[1] && !win_d[3]) begin
      tap_d = precomp_pkg::TAP_LATE; // see [R2]
    end else if (!win_d[3] && !win_d[1] && win_d[4] != win_d[0]) begin
      tap_d = win_d[4] ? precomp_pkg::TAP_EARLY : precomp_pkg::TAP_LATE; // see [R2]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cell_cnt_q <= 8'h0;
      word_q <= '0;
      left_q <= '0;
      win_q <= 5'h0;
      underrun_q <= 1'b0;
    end else begin
      if (!write_enable) begin
        cell_cnt_q <= 8'h0;
        left_q <= '0;
        win_q <= 5'h0;
      end else if (cell_tick) begin
        cell_cnt_q <= 8'(precomp_pkg::cell_cycles(rate_q) - 8'h1);
        win_q <= win_d;
        if (left_q != '0) begin
          word_q <= word_q >> 1;
          left_q <= CW'(left_q - 1'b1);
        end else if (pop) begin
          word_q <= mem[rd_ptr_q] >> 1;
          left_q <= WORD_LAST;
        end
      end else begin
        cell_cnt_q <= 8'(cell_cnt_q - 8'h1);
      end
      if (drain_ready && count_q == 2'h0) begin
        underrun_q <= 1'b1;
      end else if (access && pwrite && paddr == precomp_pkg::REG_STATUS &&
                   pwdata[precomp_pkg::ST_UNDERRUN_BIT]) begin
        underrun_q <= 1'b0;
      end
    end
  end

  // Three-stage shift register stepped every precompensation interval
  logic [2:0] shift_q;
  logic [4:0] step_len, step_cnt_q;

  assign step_len = precomp_pkg::step_cycles(rate_q, strap_q); // see [R3] see [R4]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= 3'h0;
      step_cnt_q <= 5'h0;
      tap_q <= precomp_pkg::TAP_NOMINAL;
      write_data <= 1'b0;
    end else begin
      if (cell_tick) begin
        shift_q <= {2'h0, win_d[2]}; // see [R1]
        step_cnt_q <= 5'(step_len - 5'h1);
        tap_q <= tap_d;
      end else if (step_cnt_q == 5'h0) begin
        shift_q <= {shift_q[1:0], 1'b0};
        step_cnt_q <= 5'(step_len - 5'h1);
      end else begin
        step_cnt_q <= 5'(step_cnt_q - 5'h1);
      end
      write_data <= write_enable && shift_q[tap_q]; // see [R1]
    end
  end

  function automatic logic [31:0] read_word(input logic [11:0] addr);
    logic [31:0] w;
    w = 32'h0;
    if (addr == precomp_pkg::REG_CONTROL) begin
      w[1:0] = rate_q;
    end else if (addr == precomp_pkg::REG_MODE) begin
      w[precomp_pkg::MODE_PUMP_BIT] = pump_mon_en_q;
      w[precomp_pkg::MODE_GATE_BIT] = ext_gate_en_q;
    end else if (addr == precomp_pkg::REG_STATUS) begin
      w[1:0] = rate_q;
      w[precomp_pkg::ST_STRAP_BIT] = strap_q;
      w[precomp_pkg::ST_UNDERRUN_BIT] = underrun_q;
      w[precomp_pkg::ST_WRITING_BIT] = write_enable;
      w[precomp_pkg::ST_DIV_LSB +: 5] = pll_divider;
      w[precomp_pkg::ST_VCO_BIT] = vco_center_high;
      w[precomp_pkg::ST_STEP_LSB +: 5] = step_len;
    end
    return w;
  endfunction

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_low_strap_step: assert property ( // see [R3]
    !strap_q && rate_q != precomp_pkg::RATE_1M |-> step_len == precomp_pkg::STEP_125)
    else $error("strap low shift not 125 ns");
  a_scaled_step: assert property ( // see [R4]
    strap_q && rate_q == precomp_pkg::RATE_300K |-> step_len == precomp_pkg::STEP_208)
    else $error("scaled shift at 300k not 208 ns");
  a_pump_pin_drive: assert property ( // see [R5]
    $rose(pump_mon_en_q) |=> !pump_monitor_precomp_select_pin_oe_n)
    else $error("pump pin not driven in diagnostic mode");
  a_pump_follows: assert property ( // see [R6]
    pump_mon_en_q && pump_f |=> pump_monitor_precomp_select_pin_out)
    else $error("pump monitor missed correction");
  a_ext_gate_path: assert property ( // see [R7]
    ext_gate_en_q |=> track_data == $past(gate_f))
    else $error("external read gate not followed");
  a_divider_value: assert property ( // see [R9]
    rate_q == precomp_pkg::RATE_1M ##1 rate_q == precomp_pkg::RATE_1M |->
    pll_divider == precomp_pkg::DIV_1M)
    else $error("divider not 4 at 1 Mb/s");
  a_vco_center: assert property ( // see [R10]
    ##1 vco_center_high == ($past(rate_q) == precomp_pkg::RATE_300K))
    else $error("oscillator centre wrong");
  a_filter_exclusive: assert property ( // see [R11]
    !(filter_switch_low_rate && filter_switch_mid_rate))
    else $error("both filter switches on");
  a_strap_frozen: assert property ( // see [R13]
    write_enable && $past(write_enable) |-> $stable(strap_q))
    else $error("strap changed during write");
  a_early_tap: assert property ( // see [R2]
    cell_tick && win_d[2] && tap_d == precomp_pkg::TAP_EARLY ##1 write_enable |-> ##1 write_data)
    else $error("early pulse not on first tap");
  a_late_tap: assert property ( // see [R2]
    cell_tick && win_d[2] && tap_d == precomp_pkg::TAP_LATE |-> ##2 !write_data)
    else $error("late pulse came early");
endmodule

// ### verif/floppy_drive_model.sv
// Drive side model that times the precompensated write pulses
`timescale 1ns/1ps
module floppy_drive_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic write_data,
  output int pulse_count,
  output int last_width
);
  int run_q;

  // A pulse is counted at its falling end, so its full width is known
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= 0;
      pulse_count <= 0;
      last_width <= 0;
    end else if (write_data) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      pulse_count <= pulse_count + 1;
      last_width <= run_q;
      run_q <= 0;
    end
  end
endmodule

// ### verif/write_precomp_pll_control_test.sv
// Self-checking bench for the precompensation and PLL control block
`timescale 1ns/1ps
module write_precomp_pll_control_test;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, cell_word_ready, write_data, pin_in, pin_out, pin_oe_n;
  logic write_enable = 1'b0, cell_word_valid = 1'b0, pump_up = 1'b0, pump_down = 1'b0;
  logic strap = 1'b0, core_read_gate = 1'b0, ext_read_gate = 1'b0;
  logic [7:0] cell_word = 8'h00;
  logic track_data, vco_center_high, filter_switch_low_rate, filter_switch_mid_rate;
  logic [4:0] pll_divider;
  int err_count = 0, cmp_count = 0, cycles = 0, pulse_count, last_width;

  always #5 clk = ~clk;
  // Shared pin: the device wins while it drives, else the strap level
  assign pin_in = pin_oe_n ? strap : pin_out;

  write_precomp_pll_control dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_enable(write_enable), .cell_word_valid(cell_word_valid),
    .cell_word(cell_word), .cell_word_ready(cell_word_ready), .write_data(write_data),
    .pump_up(pump_up), .pump_down(pump_down), .pump_monitor_precomp_select_pin_in(pin_in),
    .pump_monitor_precomp_select_pin_out(pin_out),
    .pump_monitor_precomp_select_pin_oe_n(pin_oe_n), .core_read_gate(core_read_gate),
    .ext_read_gate(ext_read_gate), .track_data(track_data), .pll_divider(pll_divider),
    .vco_center_high(vco_center_high), .filter_switch_low_rate(filter_switch_low_rate),
    .filter_switch_mid_rate(filter_switch_mid_rate));

  floppy_drive_model drive_u (.clk(clk), .reset(reset), .write_data(write_data),
    .pulse_count(pulse_count), .last_width(last_width));

  task results;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task push(input logic [7:0] w);
    @(posedge clk);
    cell_word_valid <= 1'b1;
    cell_word <= w;
    do begin
      @(posedge clk);
    end while (cell_word_ready !== 1'b1);
    cell_word_valid <= 1'b0;
  endtask

  task t_reset;
    chk(pll_divider, 16);
    chk({vco_center_high, filter_switch_low_rate, filter_switch_mid_rate}, 3'b010);
    chk(pin_oe_n, 1'b1);
    apb(1'b0, precomp_pkg::REG_STATUS, 32'h0);
    chk(rd[1:0], 2'h2);
  endtask

  task t_rates;
    int div[4] = '{8, 16, 16, 4};
    int ns[2][4] = '{'{125, 125, 125, 83}, '{125, 208, 250, 83}};
    logic [2:0] sw[4] = '{3'b001, 3'b110, 3'b010, 3'b000};
    for (int s = 0; s < 2; s++) begin
      strap <= s[0];
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, precomp_pkg::REG_CONTROL, 32'(i));
        repeat (5) @(posedge clk);
        chk(pll_divider, div[i]);
        chk({vco_center_high, filter_switch_low_rate, filter_switch_mid_rate}, sw[i]);
        apb(1'b0, precomp_pkg::REG_STATUS, 32'h0);
        chk(rd[15:11], (ns[s][i] * 100 + 999) / 1000);
        chk(rd[9:5], div[i]);
      end
    end
    apb(1'b0, 12'hffc, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
  endtask

  task t_pump;
    apb(1'b1, precomp_pkg::REG_MODE, 32'h1);
    repeat (4) @(posedge clk);
    chk(pin_oe_n, 1'b0);
    chk(pin_out, 1'b0);
    pump_up <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pin_out, 1'b1);
    pump_up <= 1'b0;
    pump_down <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pin_out, 1'b1);
    pump_down <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pin_out, 1'b0);
    apb(1'b1, precomp_pkg::REG_MODE, 32'h2);
    repeat (4) @(posedge clk);
    chk(pin_oe_n, 1'b1);
    core_read_gate <= 1'b1;
    ext_read_gate <= 1'b0;
    repeat (6) @(posedge clk);
    chk(track_data, 1'b0);
    ext_read_gate <= 1'b1;
    core_read_gate <= 1'b0;
    repeat (6) @(posedge clk);
    chk(track_data, 1'b1);
    apb(1'b1, precomp_pkg::REG_MODE, 32'h0);
    repeat (3) @(posedge clk);
    chk(track_data, 1'b0);
  endtask

  task t_write;
    strap <= 1'b0;
    apb(1'b1, precomp_pkg::REG_CONTROL, 32'h2);
    repeat (5) @(posedge clk);
    push(8'h11);
    // Adjacent cells in the second word give one late and one early pulse
    push(8'h13);
    repeat (2) @(posedge clk);
    chk(cell_word_ready, 1'b0);
    write_enable <= 1'b1;
    repeat (50) @(posedge clk);
    strap <= 1'b1;
    apb(1'b0, precomp_pkg::REG_STATUS, 32'h0);
    chk(rd[15:11], 13);
    chk(rd[4], 1'b1);
    while (pulse_count < 5) begin
      @(posedge clk);
    end
    // Wait past the word boundary where the empty buffer underruns
    repeat (500) @(posedge clk);
    chk(pulse_count, 5);
    chk(last_width, 13);
    apb(1'b0, precomp_pkg::REG_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    write_enable <= 1'b0;
    apb(1'b1, precomp_pkg::REG_STATUS, 32'h8);
    repeat (4) @(posedge clk);
    apb(1'b0, precomp_pkg::REG_STATUS, 32'h0);
    chk(rd[3], 1'b0);
    chk(rd[15:11], 25);
    chk(cell_word_ready, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rates();
    t_pump();
    t_write();
    results();
  end
endmodule
